// File: hdl/dsb_pkg.sv
// Purpose: Shared constants and types of the speed-bin timing checker
// Assumes: Times are held in picoseconds except tREFI in nanoseconds, grades 0..3 = 1600/1866/2133/2400
// Notes:   Bin index 0 is the fastest bin of a grade
package dsb_pkg;

   // ***************************************************************
   // Register map and reset values
   // ***************************************************************
   localparam logic [11:0] OFF_CTRL  = 12'h000;
   localparam logic [11:0] OFF_SPEED = 12'h004;
   localparam logic [11:0] OFF_LAT   = 12'h008;
   localparam logic [11:0] OFF_TCK   = 12'h00C;
   localparam logic [11:0] OFF_TREFI = 12'h010;
   localparam logic [11:0] OFF_STAT  = 12'h014;
   localparam logic [11:0] OFF_VIOL  = 12'h018;
   localparam logic [11:0] OFF_MINS  = 12'h01C;
   localparam int CTRL_EN = 0;
   localparam int CTRL_DLL = 1;
   localparam int CTRL_GD = 2;
   localparam int CTRL_DBI = 3;
   localparam int CTRL_PRE2 = 4;
   localparam logic [4:0]  CTRL_RST  = 5'h02;
   localparam logic [3:0]  SPEED_RST = 4'h0;
   localparam logic [5:0]  CL_RST    = 6'h0C;
   localparam logic [5:0]  CWL_RST   = 6'h09;
   localparam logic [11:0] TCK_RST   = 12'h4E2;
   localparam logic [15:0] TREFI_RST = 16'h1E78;

   // ***************************************************************
   // Speed-bin minimum times, picoseconds, [grade][bin], tRAS by [grade] only
   // ***************************************************************
   typedef logic [15:0] dsb_ps_t;
   localparam dsb_ps_t TAA_MAX_PS = 16'd21500;
   localparam dsb_ps_t TAA_PS [4][4] = '{
      '{16'd15000, 16'd16250, 16'd17500, 16'd17500},
      '{16'd15000, 16'd16070, 16'd17140, 16'd17140},
      '{16'd15950, 16'd16880, 16'd17140, 16'd17140},
      '{16'd15000, 16'd15830, 16'd16670, 16'd18330}};
   localparam dsb_ps_t TRCD_PS [4][4] = '{
      '{16'd13750, 16'd15000, 16'd16250, 16'd16250},
      '{16'd13750, 16'd15000, 16'd16070, 16'd16070},
      '{16'd14060, 16'd14060, 16'd15000, 16'd15000},
      '{16'd13330, 16'd14160, 16'd15000, 16'd15000}};
   localparam dsb_ps_t TRP_PS [4][4] = '{
      '{16'd12500, 16'd13750, 16'd15000, 16'd15000},
      '{16'd12850, 16'd13750, 16'd15000, 16'd15000},
      '{16'd13750, 16'd14060, 16'd15000, 16'd15000},
      '{16'd12500, 16'd14160, 16'd15000, 16'd15000}};
   localparam dsb_ps_t TRAS_PS [4] = '{16'd35000, 16'd34000, 16'd33000,
                                       16'd32000};
   localparam dsb_ps_t TRC_PS [4][4] = '{
      '{16'd47500, 16'd48750, 16'd50000, 16'd50000},
      '{16'd46850, 16'd47920, 16'd49000, 16'd49000},
      '{16'd47060, 16'd47060, 16'd48000, 16'd48000},
      '{16'd44500, 16'd46160, 16'd47000, 16'd47000}};
   localparam logic [31:0] TRASMAX_MUL = 32'd9000;

   // ***************************************************************
   // Clock-period ranges and latency limits, [range]
   // ***************************************************************
   localparam logic [11:0] TCK_LO [4] = '{12'd1250, 12'd1071, 12'd937,
                                         12'd833};
   localparam logic [11:0] TCK_HI = 12'd1900;
   localparam logic [5:0] CWL_LOW [4] = '{6'd9, 6'd10, 6'd11, 6'd12};
   localparam logic [5:0] CWL_HIGH [4] = '{6'd11, 6'd12, 6'd14, 6'd16};
   localparam logic [5:0] CL_LO [4] = '{6'd12, 6'd14, 6'd17, 6'd18};
   localparam logic [5:0] CL_HI [4] = '{6'd14, 6'd16, 6'd20, 6'd22};
   localparam logic [5:0] DBI_ADD_SLOW = 6'd2;
   localparam logic [5:0] DBI_ADD_FAST = 6'd3;

   // ***************************************************************
   // Violation and configuration-error bit positions
   // ***************************************************************
   localparam int NVIOL = 6;
   localparam int V_RCD = 0;
   localparam int V_RP = 1;
   localparam int V_RAS = 2;
   localparam int V_RASMAX = 3;
   localparam int V_RC = 4;
   localparam int V_SRE = 5;
   localparam int E_MODE = 1;
   localparam int E_CWLCL = 2;
   localparam int E_PRE2 = 3;
   localparam int E_RANGE = 4;
   localparam int E_CL = 5;
   localparam int E_TAA = 6;
   localparam int E_BIN = 7;
   localparam logic [16:0] CNT_SAT = 17'h1_FFFF;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      DSB_NOP = 3'd0, DSB_ACT = 3'd1, DSB_RD = 3'd2, DSB_WR = 3'd3,
      DSB_PRE = 3'd4, DSB_PREA = 3'd5, DSB_REF = 3'd6, DSB_SRE = 3'd7
   } dsb_op_t;
   typedef struct packed {
      logic    valid;
      dsb_op_t op;
      logic [3:0] bank;
   } dsb_cmd_t;
   typedef struct packed {
      logic        en;
      logic [11:0] tck;
      dsb_ps_t     trcd;
      dsb_ps_t     trp;
      dsb_ps_t     tras;
      dsb_ps_t     trc;
      logic [31:0] rasmax;
   } dsb_cfg_t;
endpackage

// File: hdl/dsb_checker.sv
// Purpose: Speed-bin latency and bank timing checker of a stacked DDR4 part
// Assumes: APB on mclk_i, commands arrive on the link clock lk_clk_i
// Notes:   Per-bank ages are compared as cycles x tCK against ps minima
`timescale 1ns/1ps
`default_nettype none
module dsb_checker
   import dsb_pkg::*;
(
   // System clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   // APB slave
   input  wire logic [11:0]          paddr_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // Link side
   input  wire logic                 lk_clk_i,
   input  wire dsb_pkg::dsb_cmd_t    cmd_i,
   output logic [dsb_pkg::NVIOL-1:0] lk_viol_o,
   // Status
   output logic                      cfg_ok_o
);
   import dsb_pkg::*;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic meets(input logic [16:0] n,
                                  input logic [11:0] t,
                                  input logic [31:0] m);
      return (32'(n) * 32'(t)) >= m;
   endfunction

   function automatic logic [2:0] tck_range(input logic [11:0] t);
      logic [2:0] r;
      r = 3'b000;
      if (t >= TCK_LO[0] && t <= TCK_HI) r = 3'b100;
      else if (t >= TCK_LO[1] && t < TCK_LO[0]) r = 3'b101;
      else if (t >= TCK_LO[2] && t < TCK_LO[1]) r = 3'b110;
      else if (t >= TCK_LO[3] && t < TCK_LO[2]) r = 3'b111;
      return r;
   endfunction

   // ***************************************************************
   // APB registers
   // ***************************************************************
   logic [4:0]       ctrl_reg, ctrl_next;
   logic [3:0]       speed_reg, speed_next;
   logic [5:0]       cl_reg, cl_next, cwl_reg, cwl_next;
   logic [11:0]      tck_reg, tck_next;
   logic [15:0]      trefi_reg, trefi_next;
   logic [NVIOL-1:0] viol_reg, viol_next, viol_ev;
   logic [31:0]      rdata_next;
   logic             ready_next, err_next, wr_acc, hit;
   logic [15:0]      stat_reg, stat_next;
   dsb_cfg_t         mins_reg, mins_next;
   dsb_ps_t          taa_reg, taa_next;

   assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      speed_next = speed_reg;
      cl_next = cl_reg;
      cwl_next = cwl_reg;
      tck_next = tck_reg;
      trefi_next = trefi_reg;
      viol_next = viol_reg | viol_ev;
      hit = 1'b1;
      rdata_next = 32'h0000_0000;
      unique case (paddr_i)
         OFF_CTRL:  rdata_next = {27'h000_0000, ctrl_reg};
         OFF_SPEED: rdata_next = {28'h000_0000, speed_reg};
         OFF_LAT:   rdata_next = {18'h0_0000, cwl_reg, 2'b00, cl_reg};
         OFF_TCK:   rdata_next = {20'h0_0000, tck_reg};
         OFF_TREFI: rdata_next = {16'h0000, trefi_reg};
         OFF_STAT:  rdata_next = {16'h0000, stat_reg};
         OFF_VIOL:  rdata_next = {26'h000_0000, viol_reg};
         OFF_MINS:  rdata_next = {mins_reg.trcd, taa_reg};
         default:   hit = 1'b0;
      endcase
      ready_next = psel_i & ~penable_i;
      err_next = psel_i & ~penable_i & ~hit;
      if (wr_acc && !pslverr_o)
      begin
         unique case (paddr_i)
            OFF_CTRL:  ctrl_next = pwdata_i[4:0];
            OFF_SPEED: speed_next = pwdata_i[3:0];
            OFF_LAT:
            begin
               cl_next = pwdata_i[5:0];
               cwl_next = pwdata_i[13:8];
            end
            OFF_TCK:   tck_next = pwdata_i[11:0];
            OFF_TREFI: trefi_next = pwdata_i[15:0];
            // Write one to clear; a new event in the same cycle wins
            OFF_VIOL:  viol_next = (viol_reg & ~pwdata_i[NVIOL-1:0])
                                   | viol_ev;
            default:   ;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_reg <= CTRL_RST;
         speed_reg <= SPEED_RST;
         cl_reg <= CL_RST;
         cwl_reg <= CWL_RST;
         tck_reg <= TCK_RST;
         trefi_reg <= TREFI_RST;
         viol_reg <= '0;
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         speed_reg <= speed_next;
         cl_reg <= cl_next;
         cwl_reg <= cwl_next;
         tck_reg <= tck_next;
         trefi_reg <= trefi_next;
         viol_reg <= viol_next;
         prdata_o <= rdata_next;
         pready_o <= ready_next;
         pslverr_o <= err_next;
      end
   end

   // ***************************************************************
   // Configuration check and minimum times
   // ***************************************************************
   logic [1:0] grade, bin, ridx;
   logic [2:0] rng;
   logic [5:0] dbi_add, cl_base;

   always_comb
   begin
      grade = speed_reg[1:0];
      bin = speed_reg[3:2];
      rng = tck_range(tck_reg);
      ridx = rng[1:0];
      dbi_add = (grade < 2'd2) ? DBI_ADD_SLOW : DBI_ADD_FAST;
      cl_base = ctrl_reg[CTRL_DBI] ? (cl_reg - dbi_add) : cl_reg;
      // Compatibility minima are folded into the tables
      taa_next = TAA_PS[grade][bin];
      mins_next.en = ctrl_reg[CTRL_EN];
      mins_next.tck = tck_reg;
      mins_next.trcd = TRCD_PS[grade][bin];
      mins_next.trp = TRP_PS[grade][bin];
      mins_next.tras = TRAS_PS[grade];
      mins_next.trc = TRC_PS[grade][bin];
      mins_next.rasmax = 32'(trefi_reg) * TRASMAX_MUL;
      stat_next = '0;
      stat_next[15:10] = cl_base;
      stat_next[E_MODE] = ~ctrl_reg[CTRL_DLL] | ctrl_reg[CTRL_GD];
      stat_next[E_CWLCL] = cwl_reg > cl_reg;
      stat_next[E_PRE2] = ctrl_reg[CTRL_PRE2]
                          & (cwl_reg < CWL_LOW[ridx] + 6'd1);
      stat_next[E_RANGE] = ~rng[2] | (ridx > grade)
                           | ((cwl_reg != CWL_LOW[ridx])
                              & (cwl_reg != CWL_HIGH[ridx]));
      stat_next[E_CL] = (cl_base < CL_LO[ridx])
                        | (cl_base > CL_HI[ridx]);
      stat_next[E_TAA] = ~meets(17'(cl_base), tck_reg, 32'(taa_next))
                         | meets(17'(cl_base), tck_reg,
                                 32'(TAA_MAX_PS) + 32'd1);
      stat_next[E_BIN] = (bin == 2'd3) & (grade != 2'd3);
      stat_next[0] = ~|stat_next[E_BIN:E_MODE];
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         stat_reg <= '0;
         mins_reg <= '0;
         taa_reg <= '0;
         cfg_ok_o <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         mins_reg <= mins_next;
         taa_reg <= taa_next;
         cfg_ok_o <= stat_next[0];
      end
   end

   // ***************************************************************
   // Configuration handshake toward the link domain
   // ***************************************************************
   dsb_cfg_t shd_reg, shd_next;
   logic     req_reg, req_next, ack_s1_reg, ack_s2_reg;

   always_comb
   begin
      shd_next = shd_reg;
      req_next = req_reg;
      // Shadow only moves while no transfer is outstanding
      if (req_reg == ack_s2_reg && mins_reg != shd_reg)
      begin
         shd_next = mins_reg;
         req_next = ~req_reg;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         shd_reg <= '0;
         req_reg <= 1'b0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end
      else
      begin
         shd_reg <= shd_next;
         req_reg <= req_next;
         ack_s1_reg <= lk_ack_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   // ***************************************************************
   // Link domain: reset, configuration capture
   // ***************************************************************
   logic     lk_rst_s1_reg, lk_rst;
   logic     rq_s1_reg, rq_s2_reg, lk_ack_reg;
   dsb_cfg_t lk_cfg_reg;

   always_ff @(posedge lk_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         lk_rst_s1_reg <= 1'b1;
         lk_rst <= 1'b1;
      end
      else
      begin
         lk_rst_s1_reg <= 1'b0;
         lk_rst <= lk_rst_s1_reg;
      end
   end

   always_ff @(posedge lk_clk_i or posedge lk_rst)
   begin
      if (lk_rst)
      begin
         rq_s1_reg <= 1'b0;
         rq_s2_reg <= 1'b0;
         lk_ack_reg <= 1'b0;
         lk_cfg_reg <= '0;
      end
      else
      begin
         rq_s1_reg <= req_reg;
         rq_s2_reg <= rq_s1_reg;
         lk_ack_reg <= rq_s2_reg;
         if (rq_s2_reg != lk_ack_reg)
            lk_cfg_reg <= shd_reg;
      end
   end

   // ***************************************************************
   // Link domain: per-bank ages
   // ***************************************************************
   logic [15:0] open_v, ok_rcd, ok_rp, ok_rc, ok_ras, over_ras;
   logic        is_act, is_pre, is_prea;

   assign is_act = cmd_i.valid & (cmd_i.op == DSB_ACT);
   assign is_pre = cmd_i.valid & (cmd_i.op == DSB_PRE);
   assign is_prea = cmd_i.valid & (cmd_i.op == DSB_PREA);

   for (genvar b = 0; b < 16; b++)
   begin : g_bank
      logic        open_reg, open_next;
      logic [16:0] act_reg, act_next, pre_reg, pre_next;
      logic        sel;

      always_comb
      begin
         sel = cmd_i.bank == 4'(b);
         open_next = open_reg;
         act_next = (act_reg == CNT_SAT) ? act_reg : act_reg + 17'd1;
         pre_next = (pre_reg == CNT_SAT) ? pre_reg : pre_reg + 17'd1;
         if (is_act && sel)
         begin
            open_next = 1'b1;
            act_next = 17'd1;
         end
         else if (open_reg && ((is_pre && sel) || is_prea))
         begin
            open_next = 1'b0;
            pre_next = 17'd1;
         end
      end

      always_ff @(posedge lk_clk_i or posedge lk_rst)
      begin
         if (lk_rst)
         begin
            open_reg <= 1'b0;
            act_reg <= CNT_SAT;
            pre_reg <= CNT_SAT;
         end
         else
         begin
            open_reg <= open_next;
            act_reg <= act_next;
            pre_reg <= pre_next;
         end
      end

      assign open_v[b] = open_reg;
      assign ok_rcd[b] = meets(act_reg, lk_cfg_reg.tck,
                               32'(lk_cfg_reg.trcd));
      assign ok_rp[b] = meets(pre_reg, lk_cfg_reg.tck, 32'(lk_cfg_reg.trp));
      assign ok_rc[b] = meets(act_reg, lk_cfg_reg.tck,
                              32'(lk_cfg_reg.trc));
      assign ok_ras[b] = meets(act_reg, lk_cfg_reg.tck,
                               32'(lk_cfg_reg.tras));
      assign over_ras[b] = ~meets(act_reg, lk_cfg_reg.tck,
                                  lk_cfg_reg.rasmax) ? 1'b0 : 1'b1;
   end

   // ***************************************************************
   // Link domain: violation detect and return crossing
   // ***************************************************************
   logic [NVIOL-1:0] lv, vtog_reg, vtog_next;
   logic [3:0]       bk;

   always_comb
   begin
      bk = cmd_i.bank;
      lv = '0;
      if (cmd_i.valid && lk_cfg_reg.en)
      begin
         unique case (cmd_i.op)
            DSB_RD, DSB_WR: lv[V_RCD] = ~(open_v[bk] & ok_rcd[bk]);
            DSB_ACT:
            begin
               lv[V_RP] = ~ok_rp[bk];
               lv[V_RC] = ~ok_rc[bk];
            end
            DSB_PRE:
            begin
               lv[V_RAS] = open_v[bk] & ~ok_ras[bk];
               lv[V_RASMAX] = open_v[bk] & over_ras[bk];
            end
            DSB_PREA:
            begin
               lv[V_RAS] = |(open_v & ~ok_ras);
               lv[V_RASMAX] = |(open_v & over_ras);
            end
            DSB_REF: lv[V_RC] = ~&ok_rc;
            DSB_SRE: lv[V_SRE] = |open_v | ~&ok_rp;
            default: ;
         endcase
      end
      vtog_next = vtog_reg ^ lv;
   end

   always_ff @(posedge lk_clk_i or posedge lk_rst)
   begin
      if (lk_rst)
      begin
         vtog_reg <= '0;
         lk_viol_o <= '0;
      end
      else
      begin
         vtog_reg <= vtog_next;
         lk_viol_o <= lv;
      end
   end

   logic [NVIOL-1:0] vs1_reg, vs2_reg, vs3_reg;

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         vs1_reg <= '0;
         vs2_reg <= '0;
         vs3_reg <= '0;
      end
      else
      begin
         vs1_reg <= vtog_reg;
         vs2_reg <= vs1_reg;
         vs3_reg <= vs2_reg;
      end
   end

   assign viol_ev = vs2_reg ^ vs3_reg;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_bad_mode;
      !ctrl_reg[CTRL_DLL] || ctrl_reg[CTRL_GD];
   endsequence

   a_mode_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      s_bad_mode |=> !stat_reg[0] && !cfg_ok_o)
      else $error("bad DLL or gear-down mode not flagged");

   a_dbi_slow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (ctrl_reg[CTRL_DBI] && grade < 2'd2) |=>
         stat_reg[15:10] == $past(cl_reg) - 6'd2)
      else $error("DBI adder for slow grades is not two");

   a_dbi_fast: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (ctrl_reg[CTRL_DBI] && grade >= 2'd2) |=>
         stat_reg[15:10] == $past(cl_reg) - 6'd3)
      else $error("DBI adder for fast grades is not three");

   a_compat_rcd: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (speed_reg == 4'h1 || speed_reg == 4'h2) ##1 $stable(speed_reg)
         |-> ((speed_reg == 4'h1) ? mins_reg.trcd : mins_reg.trp)
             == 16'd13750)
      else $error("compatibility activate or precharge time not accepted");

   a_compat_taa: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (speed_reg == 4'h9) |=> taa_reg == 16'd17140)
      else $error("compatibility read latency not accepted");

   sequence s_rd_closed;
      cmd_i.valid && lk_cfg_reg.en && cmd_i.op == DSB_RD && !open_v[bk];
   endsequence

   a_rcd_flag: assert property (@(posedge lk_clk_i) disable iff (lk_rst)
      s_rd_closed |=> lk_viol_o[V_RCD] ##[3:6] viol_reg[V_RCD])
      else $error("read to closed bank not flagged");
endmodule
`default_nettype wire

// File: verif/dsb_ctl_model.sv
// Purpose: Memory controller model driving link commands
// Assumes: tck_ps equals the programmed TCK value
// Notes:   Idle fields toggle so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module dsb_ctl_model
   import dsb_pkg::*;
(
   // Link side
   input  wire logic            lk_clk_i,
   output var dsb_pkg::dsb_cmd_t cmd_o
);
   int tck_ps = 1250;
   initial cmd_o = '0;
   // Minimum in ps to whole link cycles, rounded up
   function automatic int cyc(input int ps);
      return (ps + tck_ps - 1) / tck_ps;
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge lk_clk_i)
         cmd_o <= '{1'b0, dsb_op_t'(~cmd_o.op), ~cmd_o.bank};
   endtask
   // Callers give the spacing n in link cycles, either cyc() of a minimum or a fixed count
   task automatic send(input dsb_op_t op, input logic [3:0] b,
                       input int n);
      idle(n - 1);
      @(posedge lk_clk_i) cmd_o <= '{1'b1, op, b};
   endtask
endmodule
`default_nettype wire

// File: verif/tb_dsb_checker.sv
// Purpose: Self-checking bench of the speed-bin checker
// Assumes: APB answers in the cycle after setup
// Notes:   Link clock 6 ns with a phase offset
`timescale 1ns/1ps
`default_nettype none
module tb_dsb_checker
   import dsb_pkg::*;
;
   logic        mclk_i = 0, lk_clk_i = 0, sys_rst_i = 1;
   logic        psel_i, penable_i, pwrite_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd_q;
   logic        pready_o, pslverr_o, cfg_ok_o, err_q;
   dsb_cmd_t    cmd_i;
   logic [5:0]  lk_viol_o, acc = '0;
   int          error_cnt = 0, checked = 0, cyc_cnt = 0;
   // ctrl, speed, lat, tck, expected masked status
   logic [79:0] cf [15] = '{
      80'h0007_0000_090C_04E2_3002, 80'h0001_0000_090C_04E2_3002,
      80'h0013_0000_090C_04E2_3008, 80'h0013_0000_0B0C_04E2_3001,
      80'h0003_0000_090C_03E8_3010, 80'h0003_0001_0A0E_044C_3801,
      80'h0003_0001_0A0D_044C_3420, 80'h0003_0002_0B11_03E8_4401,
      80'h0003_0003_0C14_0384_5001, 80'h0003_000D_0A0E_044C_3880,
      80'h000B_0000_090E_04E2_3001, 80'h000B_0000_090C_04E2_2820,
      80'h000B_0002_0B14_03E8_4401, 80'h0003_000A_0B12_03E8_4801,
      80'h0003_000A_0B11_03E8_4440};
   dsb_checker dsb_checker_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .lk_clk_i(lk_clk_i),
      .cmd_i(cmd_i), .lk_viol_o(lk_viol_o), .cfg_ok_o(cfg_ok_o));
   dsb_ctl_model dsb_ctl_model_i (.lk_clk_i(lk_clk_i), .cmd_o(cmd_i));
   initial forever #2 mclk_i = ~mclk_i;
   initial
   begin
      #1.3;
      forever #3 lk_clk_i = ~lk_clk_i;
   end
   always @(posedge lk_clk_i) acc <= acc | lk_viol_o;
   always @(posedge mclk_i)
      if (++cyc_cnt == 20000)
      begin
         error_cnt++;
         results();
      end
   task automatic results();
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Request stands until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i) penable_i <= 1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, '0);
      cmp(rd_q, e);
   endtask
   task automatic cfg(input logic [15:0] c, s, l, t);
      apb(1, OFF_CTRL, {16'h0000, c});
      apb(1, OFF_SPEED, {16'h0000, s});
      apb(1, OFF_LAT, {16'h0000, l});
      apb(1, OFF_TCK, {16'h0000, t});
   endtask
   task automatic sd(input dsb_op_t op, input logic [3:0] b, input int n);
      dsb_ctl_model_i.send(op, b, n);
   endtask
   task automatic lk(input logic [5:0] e);
      dsb_ctl_model_i.idle(4);
      @(posedge mclk_i);
      cmp({26'h0, acc}, {26'h0, e});
      acc = '0;
   endtask
   initial
   begin
      psel_i <= 0;
      penable_i <= 0;
      pwrite_i <= 0;
      paddr_i <= '0;
      pwdata_i <= '0;
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 0;
      rdc(OFF_CTRL, 32'h0000_0002);
      rdc(OFF_LAT, 32'h0000_090C);
      cmp(cfg_ok_o, 1'b1);
      rdc(12'h020, 32'h0000_0000);
      cmp(err_q, 1'b1);
      foreach (cf[i])
      begin
         cfg(cf[i][79:64], cf[i][63:48], cf[i][47:32], cf[i][31:16]);
         apb(0, OFF_STAT, '0);
         cmp(rd_q & (32'h0000_FC01 | cf[i][7:0]), cf[i][15:0]);
         cmp(cfg_ok_o, cf[i][0]);
      end
      apb(1, OFF_SPEED, 32'h0000_0001);
      rdc(OFF_MINS, 32'h35B6_3A98);
      apb(1, OFF_SPEED, 32'h0000_000A);
      rdc(OFF_MINS, 32'h3A98_42F4);
      cfg(16'h0003, 16'h0000, 16'h090C, 16'h04E2);
      repeat (30) @(posedge mclk_i);
      sd(DSB_ACT, 3, 1);
      sd(DSB_RD, 3, 1);
      lk(6'h01);
      repeat (8) @(posedge mclk_i);
      rdc(OFF_VIOL, 32'h0000_0001);
      apb(1, OFF_VIOL, 32'h0000_003F);
      rdc(OFF_VIOL, 32'h0000_0000);
      sd(DSB_ACT, 1, 1);
      sd(DSB_WR, 1, dsb_ctl_model_i.cyc(13750));
      lk(6'h00);
      sd(DSB_PRE, 1, 1);
      sd(DSB_ACT, 1, 1);
      lk(6'h16);
      sd(DSB_ACT, 2, 1);
      sd(DSB_PRE, 2, dsb_ctl_model_i.cyc(35000));
      sd(DSB_ACT, 2, dsb_ctl_model_i.cyc(12500));
      lk(6'h00);
      sd(DSB_SRE, 0, dsb_ctl_model_i.cyc(12500));
      lk(6'h20);
      sd(DSB_PREA, 0, dsb_ctl_model_i.cyc(35000));
      sd(DSB_SRE, 0, dsb_ctl_model_i.cyc(12500));
      lk(6'h00);
      apb(1, OFF_TREFI, 32'h0000_000A);
      repeat (30) @(posedge mclk_i);
      sd(DSB_ACT, 4, 1);
      sd(DSB_PRE, 4, 80);
      lk(6'h08);
      apb(1, OFF_CTRL, 32'h0000_0002);
      repeat (30) @(posedge mclk_i);
      sd(DSB_ACT, 5, 1);
      sd(DSB_RD, 6, 1);
      lk(6'h00);
      results();
   end
endmodule
`default_nettype wire
